// file: shared/ftc_pkg.sv
// constants and types for the flag test and control transfer core
package ftc_pkg;

    // register byte offsets
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_OPA    = 8'h08;
    localparam logic [7:0] ADDR_OPB    = 8'h0C;
    localparam logic [7:0] ADDR_SEL    = 8'h10;
    localparam logic [7:0] ADDR_IP     = 8'h14;
    localparam logic [7:0] ADDR_CS     = 8'h18;
    localparam logic [7:0] ADDR_SP     = 8'h1C;
    localparam logic [7:0] ADDR_FLAGS  = 8'h20;
    localparam logic [7:0] ADDR_RESULT = 8'h24;

    // control field positions
    localparam int CTRL_OP_LSB   = 0;
    localparam int CTRL_MODE_LSB = 4;
    localparam int CTRL_COND_LSB = 8;
    localparam int CTRL_PROT_BIT = 12;
    localparam int CTRL_GO_BIT   = 31;

    // status bit positions
    localparam int STAT_BUSY  = 0;
    localparam int STAT_DONE  = 1;
    localparam int STAT_ERR   = 2;
    localparam int STAT_TAKEN = 3;

    // flag bit positions in flags_register
    localparam int FLAG_CARRY    = 0;
    localparam int FLAG_PARITY   = 2;
    localparam int FLAG_ZERO     = 6;
    localparam int FLAG_SIGN     = 7;
    localparam int FLAG_OVERFLOW = 11;

    // reset values and stack step
    localparam logic [31:0] FLAGS_RESET = 32'h0000_0002;
    localparam logic [31:0] IP_RESET    = 32'h0000_0000;
    localparam logic [31:0] SP_RESET    = 32'h0000_0000;
    localparam logic [15:0] CS_RESET    = 16'h0000;
    localparam logic [31:0] WORD_BYTES  = 32'h0000_0004;

    // bus answers
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        OP_BYTE_SET  = 4'h0,
        OP_TEST      = 4'h1,
        OP_JUMP      = 4'h2,
        OP_CALL      = 4'h3,
        OP_PROC_EXIT = 4'h4,
        OP_INT_EXIT  = 4'h5,
        OP_INT       = 4'h6,
        OP_JCC       = 4'h7
    } ftc_op_t;

    typedef enum logic [1:0] {
        TGT_REL      = 2'h0,
        TGT_REG      = 2'h1,
        TGT_MEM_NEAR = 2'h2,
        TGT_MEM_FAR  = 2'h3
    } ftc_tgt_t;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'h0,
        ST_PUSH_FL = 3'h1,
        ST_PUSH_IP = 3'h2,
        ST_POP_IP  = 3'h3,
        ST_POP_FL  = 3'h4,
        ST_LD_OFF  = 3'h5,
        ST_LD_SEL  = 3'h6
    } ftc_fsm_t;

endpackage

// file: logic/ftc_core.sv
// flag test, byte set and control transfer execution core
// Summary of operation
// - byte set writes 0 or 1 from the selected condition on flags.
// - overflow byte set writes 1 when overflow set, else 0.
// - test ANDs operands, updates sign, zero and parity flags.
// - test leaves operands unchanged and discards the AND result.
// - conditional transfers redirect only on true condition; others always.
// - jump redirects without saving any return address.
// - relative target is ip plus signed displacement, forward or backward.
// - register target loads ip as near pointer, code segment kept.
// - memory near loads ip; memory far loads selector and offset.
// - protected mode accepts gate and task targets on far jumps.
// - call pushes the following instruction address before transfer.
// - call takes the same target forms as a jump.
// - return pops the saved address into ip and continues there.
// - return immediate is added to stack pointer, freeing parameters.
// - interrupt pushes flags and return address, then calls handler.
// - interrupt return pops ip like return and restores flags.
`timescale 1ns/1ps
`default_nettype none

module ftc_core (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             mem_req,
    output logic             mem_we,
    output logic [31:0]      mem_addr,
    output logic [31:0]      mem_wdata,
    input  wire logic [31:0] mem_rdata,
    input  wire logic        mem_ack,
    output logic             gate_xfer
);

    typedef struct packed {
        logic              awv;
        logic [7:0]        awaddr;
        logic              wv;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
        ftc_pkg::ftc_fsm_t fsm;
        ftc_pkg::ftc_op_t  op;
        ftc_pkg::ftc_tgt_t mode;
        logic [3:0]        cond;
        logic              prot;
        logic              start;
        logic              done;
        logic              err;
        logic              taken;
        logic [31:0]       opa;
        logic [31:0]       opb;
        logic [31:0]       sel;
        logic [31:0]       ip;
        logic [15:0]       cs;
        logic [31:0]       sp;
        logic [31:0]       flags;
        logic [7:0]        result;
        logic              mem_req;
        logic              mem_we;
        logic [31:0]       mem_addr;
        logic [31:0]       mem_wdata;
        logic              gate_xfer;
    } ftc_reg_t;

    localparam ftc_reg_t RST = '{
        fsm:     ftc_pkg::ST_IDLE,
        op:      ftc_pkg::OP_BYTE_SET,
        mode:    ftc_pkg::TGT_REL,
        ip:      ftc_pkg::IP_RESET,
        cs:      ftc_pkg::CS_RESET,
        sp:      ftc_pkg::SP_RESET,
        flags:   ftc_pkg::FLAGS_RESET,
        default: '0
    };

    ftc_reg_t st;
    ftc_reg_t next_st;

    // condition code evaluation, low bit inverts
    function automatic logic cond_met(input logic [3:0]  c,
                                      input logic [31:0] f);
        logic o;
        logic cy;
        logic z;
        logic s;
        logic p;
        logic t;
        o  = f[ftc_pkg::FLAG_OVERFLOW];
        cy = f[ftc_pkg::FLAG_CARRY];
        z  = f[ftc_pkg::FLAG_ZERO];
        s  = f[ftc_pkg::FLAG_SIGN];
        p  = f[ftc_pkg::FLAG_PARITY];
        unique case (c[3:1])
            3'h0: t = o;
            3'h1: t = cy;
            3'h2: t = z;
            3'h3: t = cy | z;
            3'h4: t = s;
            3'h5: t = p;
            3'h6: t = s ^ o;
            3'h7: t = (s ^ o) | z;
        endcase
        return t ^ c[0];
    endfunction

    // register read mux, top bit marks a mapped address
    function automatic logic [32:0] reg_read(input ftc_reg_t   s,
                                             input logic [7:0] a);
        logic [32:0] r;
        r = {1'b1, 32'h0};
        unique case (a)
            ftc_pkg::ADDR_CTRL:   r[31:0] = {19'h0, s.prot, s.cond,
                                             2'h0, s.mode, s.op};
            ftc_pkg::ADDR_STATUS: r[31:0] = {28'h0, s.taken, s.err,
                                             s.done, s.start |
                                             (s.fsm != ftc_pkg::ST_IDLE)};
            ftc_pkg::ADDR_OPA:    r[31:0] = s.opa;
            ftc_pkg::ADDR_OPB:    r[31:0] = s.opb;
            ftc_pkg::ADDR_SEL:    r[31:0] = s.sel;
            ftc_pkg::ADDR_IP:     r[31:0] = s.ip;
            ftc_pkg::ADDR_CS:     r[31:0] = {16'h0, s.cs};
            ftc_pkg::ADDR_SP:     r[31:0] = s.sp;
            ftc_pkg::ADDR_FLAGS:  r[31:0] = s.flags;
            ftc_pkg::ADDR_RESULT: r[31:0] = {24'h0, s.result};
            default:              r = 33'h0;
        endcase
        return r;
    endfunction

    // byte lane merge for writes
    function automatic logic [31:0] wmerge(input logic [31:0] old,
                                           input logic [31:0] d,
                                           input logic [3:0]  be);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                m[8*i +: 8] = d[8*i +: 8];
            end
        end
        return m;
    endfunction

    always_comb begin
        logic [32:0] rr;
        logic [31:0] m;
        logic [31:0] t;
        logic        busy;
        logic        fin;
        logic        resolve;
        logic        cm;
        rr      = 33'h0;
        m       = 32'h0;
        t       = 32'h0;
        fin     = 1'b0;
        resolve = 1'b0;
        busy    = st.start | (st.fsm != ftc_pkg::ST_IDLE);
        cm      = cond_met(st.cond, st.flags);
        next_st = st;
        next_st.gate_xfer = 1'b0;

        // bus write side
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end
        if (!st.awv && s_axi_awvalid) begin
            next_st.awv    = 1'b1;
            next_st.awaddr = s_axi_awaddr;
        end
        if (!st.wv && s_axi_wvalid) begin
            next_st.wv    = 1'b1;
            next_st.wdata = s_axi_wdata;
            next_st.wstrb = s_axi_wstrb;
        end
        if (st.awv && st.wv && !st.bvalid) begin
            rr = reg_read(st, st.awaddr);
            m  = wmerge(rr[31:0], st.wdata, st.wstrb);
            next_st.awv    = 1'b0;
            next_st.wv     = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp  = ftc_pkg::RESP_OKAY;
            if (!rr[32] || (busy && st.awaddr != ftc_pkg::ADDR_STATUS
                            && st.awaddr != ftc_pkg::ADDR_RESULT)) begin
                next_st.bresp = ftc_pkg::RESP_SLVERR;
            end else begin
                unique case (st.awaddr)
                    ftc_pkg::ADDR_CTRL: begin
                        next_st.op   = ftc_pkg::ftc_op_t'(
                            m[ftc_pkg::CTRL_OP_LSB +: 4]);
                        next_st.mode = ftc_pkg::ftc_tgt_t'(
                            m[ftc_pkg::CTRL_MODE_LSB +: 2]);
                        next_st.cond = m[ftc_pkg::CTRL_COND_LSB +: 4];
                        next_st.prot = m[ftc_pkg::CTRL_PROT_BIT];
                        if (st.wstrb[3] && st.wdata[ftc_pkg::CTRL_GO_BIT]) begin
                            next_st.start = 1'b1;
                            next_st.done  = 1'b0;
                            next_st.err   = 1'b0;
                            next_st.taken = 1'b0;
                        end
                    end
                    ftc_pkg::ADDR_OPA:   next_st.opa   = m;
                    ftc_pkg::ADDR_OPB:   next_st.opb   = m;
                    ftc_pkg::ADDR_SEL:   next_st.sel   = m;
                    ftc_pkg::ADDR_IP:    next_st.ip    = m;
                    ftc_pkg::ADDR_CS:    next_st.cs    = m[15:0];
                    ftc_pkg::ADDR_SP:    next_st.sp    = m;
                    ftc_pkg::ADDR_FLAGS: next_st.flags = m;
                    default: ;
                endcase
            end
        end

        // bus read side
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        if (!st.rvalid && s_axi_arvalid) begin
            rr = reg_read(st, s_axi_araddr);
            next_st.rvalid = 1'b1;
            next_st.rdata  = rr[31:0];
            next_st.rresp  = rr[32] ? ftc_pkg::RESP_OKAY
                                    : ftc_pkg::RESP_SLVERR;
        end

        // execution sequencer
        unique case (st.fsm)
            ftc_pkg::ST_IDLE: begin
                if (st.start) begin
                    next_st.start = 1'b0;
                    unique case (st.op)
                        ftc_pkg::OP_BYTE_SET: begin
                            next_st.result = {7'h0, cm};
                            fin = 1'b1;
                        end
                        ftc_pkg::OP_TEST: begin
                            t = st.opa & st.opb;
                            next_st.flags[ftc_pkg::FLAG_SIGN]   = t[31];
                            next_st.flags[ftc_pkg::FLAG_ZERO]   = (t == 32'h0);
                            next_st.flags[ftc_pkg::FLAG_PARITY] = ~^t[7:0];
                            fin = 1'b1;
                        end
                        ftc_pkg::OP_JCC: begin
                            if (cm) begin
                                next_st.ip    = st.ip + st.opb;
                                next_st.taken = 1'b1;
                            end
                            fin = 1'b1;
                        end
                        ftc_pkg::OP_JUMP: resolve = 1'b1;
                        ftc_pkg::OP_CALL: begin
                            next_st.fsm       = ftc_pkg::ST_PUSH_IP;
                            next_st.mem_req   = 1'b1;
                            next_st.mem_we    = 1'b1;
                            next_st.mem_addr  = st.sp - ftc_pkg::WORD_BYTES;
                            next_st.mem_wdata = st.ip;
                        end
                        ftc_pkg::OP_INT: begin
                            next_st.fsm       = ftc_pkg::ST_PUSH_FL;
                            next_st.mem_req   = 1'b1;
                            next_st.mem_we    = 1'b1;
                            next_st.mem_addr  = st.sp - ftc_pkg::WORD_BYTES;
                            next_st.mem_wdata = st.flags;
                        end
                        ftc_pkg::OP_PROC_EXIT,
                        ftc_pkg::OP_INT_EXIT: begin
                            next_st.fsm      = ftc_pkg::ST_POP_IP;
                            next_st.mem_req  = 1'b1;
                            next_st.mem_we   = 1'b0;
                            next_st.mem_addr = st.sp;
                        end
                        default: begin
                            next_st.err = 1'b1;
                            fin = 1'b1;
                        end
                    endcase
                end
            end
            ftc_pkg::ST_PUSH_FL: begin
                if (mem_ack) begin
                    next_st.sp        = st.sp - ftc_pkg::WORD_BYTES;
                    next_st.fsm       = ftc_pkg::ST_PUSH_IP;
                    next_st.mem_addr  = next_st.sp - ftc_pkg::WORD_BYTES;
                    next_st.mem_wdata = st.ip;
                end
            end
            ftc_pkg::ST_PUSH_IP: begin
                if (mem_ack) begin
                    next_st.sp      = st.sp - ftc_pkg::WORD_BYTES;
                    next_st.mem_req = 1'b0;
                    next_st.mem_we  = 1'b0;
                    if (st.op == ftc_pkg::OP_INT) begin
                        next_st.ip    = st.opb;
                        next_st.cs    = st.sel[15:0];
                        next_st.taken = 1'b1;
                        fin = 1'b1;
                    end else begin
                        resolve = 1'b1;
                    end
                end
            end
            ftc_pkg::ST_POP_IP: begin
                if (mem_ack) begin
                    next_st.ip    = mem_rdata;
                    next_st.taken = 1'b1;
                    next_st.sp    = st.sp + ftc_pkg::WORD_BYTES;
                    if (st.op == ftc_pkg::OP_INT_EXIT) begin
                        next_st.fsm      = ftc_pkg::ST_POP_FL;
                        next_st.mem_addr = next_st.sp;
                    end else begin
                        next_st.sp      = next_st.sp + st.opb;
                        next_st.mem_req = 1'b0;
                        fin = 1'b1;
                    end
                end
            end
            ftc_pkg::ST_POP_FL: begin
                if (mem_ack) begin
                    next_st.flags   = mem_rdata;
                    next_st.sp      = st.sp + ftc_pkg::WORD_BYTES;
                    next_st.mem_req = 1'b0;
                    fin = 1'b1;
                end
            end
            ftc_pkg::ST_LD_OFF: begin
                if (mem_ack) begin
                    next_st.ip    = mem_rdata;
                    next_st.taken = 1'b1;
                    if (st.mode == ftc_pkg::TGT_MEM_FAR) begin
                        next_st.fsm      = ftc_pkg::ST_LD_SEL;
                        next_st.mem_addr = st.opa + ftc_pkg::WORD_BYTES;
                    end else begin
                        next_st.mem_req = 1'b0;
                        fin = 1'b1;
                    end
                end
            end
            ftc_pkg::ST_LD_SEL: begin
                if (mem_ack) begin
                    next_st.cs      = mem_rdata[15:0];
                    next_st.mem_req = 1'b0;
                    // gate or task target handed out
                    next_st.gate_xfer = st.prot;
                    fin = 1'b1;
                end
            end
            default: begin
                next_st.fsm     = ftc_pkg::ST_IDLE;
                next_st.mem_req = 1'b0;
            end
        endcase

        // target resolution shared by jump and call
        if (resolve) begin
            unique case (st.mode)
                ftc_pkg::TGT_REL: begin
                    next_st.ip    = st.ip + st.opb;
                    next_st.taken = 1'b1;
                    fin = 1'b1;
                end
                ftc_pkg::TGT_REG: begin
                    next_st.ip    = st.opb;
                    next_st.taken = 1'b1;
                    fin = 1'b1;
                end
                ftc_pkg::TGT_MEM_NEAR,
                ftc_pkg::TGT_MEM_FAR: begin
                    next_st.fsm      = ftc_pkg::ST_LD_OFF;
                    next_st.mem_req  = 1'b1;
                    next_st.mem_we   = 1'b0;
                    next_st.mem_addr = st.opa;
                end
            endcase
        end

        if (fin) begin
            next_st.fsm  = ftc_pkg::ST_IDLE;
            next_st.done = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= RST;
        end else begin
            st <= next_st;
        end
    end

    assign s_axi_awready = !st.awv;
    assign s_axi_wready  = !st.wv;
    assign s_axi_bvalid  = st.bvalid;
    assign s_axi_bresp   = st.bresp;
    assign s_axi_arready = !st.rvalid;
    assign s_axi_rvalid  = st.rvalid;
    assign s_axi_rdata   = st.rdata;
    assign s_axi_rresp   = st.rresp;
    assign mem_req       = st.mem_req;
    assign mem_we        = st.mem_we;
    assign mem_addr      = st.mem_addr;
    assign mem_wdata     = st.mem_wdata;
    assign gate_xfer     = st.gate_xfer;

endmodule

`default_nettype wire

// file: tb/ftc_mem.sv
// program and stack memory model facing the core
`timescale 1ns/1ps
`default_nettype none
module ftc_mem (
    input  wire logic        aclk,
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic [31:0] mem_addr,
    input  wire logic [31:0] mem_wdata,
    input  wire logic        stall,
    output logic [31:0]      mem_rdata,
    output logic             mem_ack
);
    logic [31:0] m [logic [31:0]];
    logic        take;
    initial begin
        mem_ack = 1'b0;
        mem_rdata = 32'h0;
    end
    assign take = mem_req && !mem_ack && !stall;
    // data only valid with ack, otherwise a toggling pattern
    always @(posedge aclk) begin
        if (mem_req && mem_ack && mem_we)
            m[mem_addr] = mem_wdata;
        mem_ack <= take;
        if (take && m.exists(mem_addr))
            mem_rdata <= m[mem_addr];
        else
            mem_rdata <= ~mem_rdata;
    end
endmodule
`default_nettype wire

// file: tb/ftc_core_props.sv
// assertions on the core's memory, gate and read ports
`timescale 1ns/1ps
`default_nettype none
module ftc_core_props (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        mem_req,
    input wire logic        mem_we,
    input wire logic        mem_ack,
    input wire logic [31:0] mem_addr,
    input wire logic        gate_xfer
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_req_hold: assert property (mem_req && !mem_ack |=>
        mem_req && $stable(mem_addr) && $stable(mem_we))
        else $error("memory request dropped or changed");
    chk_push_step: assert property (mem_req && mem_ack && mem_we ##1
        mem_req && mem_we |-> mem_addr == $past(mem_addr) - 32'h4)
        else $error("push address did not step down");
    chk_pop_step: assert property (mem_req && mem_ack && !mem_we ##1
        mem_req && !mem_we |-> mem_addr == $past(mem_addr) + 32'h4)
        else $error("read address did not step up");
    chk_gate_src: assert property (gate_xfer |->
        $past(mem_req && mem_ack && !mem_we))
        else $error("gate pulse without a final read");
    chk_gate_pulse: assert property (gate_xfer |=> !gate_xfer)
        else $error("gate pulse longer than one cycle");
    chk_gate_idle: assert property (mem_req |-> !gate_xfer)
        else $error("gate pulse during memory access");
    chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid)
        else $error("read answer late");
    chk_ar_block: assert property (s_axi_arready == !s_axi_rvalid)
        else $error("read address ready wrong");
    cover property (gate_xfer);
    cover property (mem_req && mem_ack && mem_we ##1 mem_req && mem_we);
    cover property (mem_req && mem_ack && !mem_we ##1 mem_req && !mem_we);
endmodule
bind ftc_core ftc_core_props chk (.aclk(aclk), .aresetn(aresetn),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .mem_req(mem_req), .mem_we(mem_we),
    .mem_ack(mem_ack), .mem_addr(mem_addr), .gate_xfer(gate_xfer));
`default_nettype wire

// file: tb/tb_ftc_core.sv
// self-checking bench for the control transfer core
`timescale 1ns/1ps
`default_nettype none
module tb_ftc_core;
    logic        aclk = 0, aresetn = 0, awv = 0, wv = 0, arv = 0, stall = 0;
    logic        chk_on = 0, aw_r, w_r, bv, ar_r, rv, mreq, mwe, mack, gx;
    logic [1:0]  bresp, rresp, bexp = 2'h0;
    logic [7:0]  awa = 0, ara = 0;
    logic [31:0] wd = 0, rdat, ma, mwd, mrd, v, a, b, f, t;
    logic [33:0] q [$];
    int          err_total = 0, n_tests = 0, cyc = 0, seed = 97860, n_gx = 0;
    ftc_core dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(aw_r), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(w_r),
        .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(1'b1),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(ar_r),
        .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
        .s_axi_rready(1'b1), .mem_req(mreq), .mem_we(mwe), .mem_addr(ma),
        .mem_wdata(mwd), .mem_rdata(mrd), .mem_ack(mack), .gate_xfer(gx));
    ftc_mem mem (.aclk(aclk), .mem_req(mreq), .mem_we(mwe), .mem_addr(ma),
        .mem_wdata(mwd), .stall(stall), .mem_rdata(mrd), .mem_ack(mack));
    always #12.5 aclk = ~aclk;
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic cmp(input logic [33:0] e, input logic [33:0] g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("wrong value t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        stall <= ($random(seed) & 3) == 0;
        if (cyc == 20000) begin
            err_total++;
            finish_test();
        end
    end
    always @(posedge aclk)
        if (rv && chk_on)
            cmp(q.pop_front(), {rresp, rdat});
    // gate pulses counted, write answers checked
    always @(posedge aclk) begin
        if (gx) n_gx++;
        if (bv) cmp({32'h0, bexp}, {32'h0, bresp});
    end
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        logic k;
        awa <= ad;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        k = 1'b0;
        while (!k) begin
            @(posedge aclk);
            if (awv && aw_r) awv <= 1'b0;
            if (wv && w_r) wv <= 1'b0;
            k = bv;
        end
    endtask
    task automatic rd(input logic [7:0] ad, input logic c,
                      output logic [31:0] d);
        logic k;
        ara <= ad;
        arv <= 1'b1;
        chk_on <= c;
        k = 1'b0;
        while (!k) begin
            @(posedge aclk);
            if (arv && ar_r) arv <= 1'b0;
            k = rv;
            d = rdat;
        end
    endtask
    task automatic ex(input logic [7:0] ad, input logic [33:0] e);
        q.push_back(e);
        rd(ad, 1'b1, v);
    endtask
    task automatic go(input logic [31:0] c);
        wr(8'h00, c | 32'h8000_0000);
        v = 32'h0;
        while (v[ftc_pkg::STAT_DONE] !== 1'b1)
            rd(8'h04, 1'b0, v);
    endtask
    function automatic logic cnd(input logic [3:0] c, input logic [31:0] x);
        logic o, s, z, p, cy;
        logic [7:0] m;
        o = x[ftc_pkg::FLAG_OVERFLOW];
        s = x[ftc_pkg::FLAG_SIGN];
        z = x[ftc_pkg::FLAG_ZERO];
        p = x[ftc_pkg::FLAG_PARITY];
        cy = x[ftc_pkg::FLAG_CARRY];
        m = {(s ^ o) | z, s ^ o, p, s, cy | z, z, cy, o};
        return m[c[3:1]] ^ c[0];
    endfunction
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        ex(8'h20, 34'h2);
        for (int c = 0; c < 16; c++) begin
            f = $random(seed);
            wr(8'h20, f);
            go({20'h0, c[3:0], 8'h00});
            ex(8'h24, {33'h0, cnd(c[3:0], f)});
            wr(8'h14, 32'h100);
            wr(8'h0C, 32'hFFFF_FFF0);
            go({20'h0, c[3:0], 8'h07});
            ex(8'h14, cnd(c[3:0], f) ? 34'hF0 : 34'h100);
        end
        a = $random(seed);
        b = $random(seed);
        t = a & b;
        wr(8'h08, a);
        wr(8'h0C, b);
        go(32'h1);
        f[ftc_pkg::FLAG_SIGN] = t[31];
        f[ftc_pkg::FLAG_ZERO] = t == 32'h0;
        f[ftc_pkg::FLAG_PARITY] = ~^t[7:0];
        ex(8'h20, {2'h0, f});
        ex(8'h08, {2'h0, a});
        ex(8'h0C, {2'h0, b});
        wr(8'h14, 32'h100);
        wr(8'h1C, 32'h80);
        wr(8'h0C, 32'hFFFF_FFF0);
        go(32'h2);
        ex(8'h14, 34'hF0);
        ex(8'h1C, 34'h80);
        wr(8'h18, 32'h12);
        wr(8'h0C, 32'h345);
        go(32'h12);
        ex(8'h14, 34'h345);
        ex(8'h18, 34'h12);
        mem.m[32'h400] = 32'h777;
        mem.m[32'h404] = 32'h9ABC;
        wr(8'h08, 32'h404);
        go(32'h22);
        ex(8'h14, 34'h9ABC);
        wr(8'h08, 32'h400);
        go(32'h1032);
        ex(8'h14, 34'h777);
        ex(8'h18, 34'h9ABC);
        cmp(34'h1, {2'h0, n_gx});
        wr(8'h14, 32'h40);
        wr(8'h0C, 32'h10);
        wr(8'h1C, 32'h100);
        go(32'h3);
        ex(8'h14, 34'h50);
        ex(8'h1C, 34'hFC);
        cmp(34'h40, {2'h0, mem.m[32'hFC]});
        wr(8'h0C, 32'h8);
        go(32'h4);
        ex(8'h14, 34'h40);
        ex(8'h1C, 34'h108);
        wr(8'h14, 32'h60);
        wr(8'h1C, 32'h200);
        wr(8'h0C, 32'h900);
        wr(8'h10, 32'h33);
        go(32'h6);
        ex(8'h14, 34'h900);
        ex(8'h1C, 34'h1F8);
        cmp({2'h0, f}, {2'h0, mem.m[32'h1FC]});
        cmp(34'h60, {2'h0, mem.m[32'h1F8]});
        wr(8'h20, 32'h2);
        go(32'h5);
        ex(8'h14, 34'h60);
        ex(8'h20, {2'h0, f});
        ex(8'h1C, 34'h200);
        ex(8'h40, {ftc_pkg::RESP_SLVERR, 32'h0});
        bexp = ftc_pkg::RESP_SLVERR;
        wr(8'h40, 32'h1);
        @(posedge aclk);
        finish_test();
    end
endmodule
`default_nettype wire
